// [core/tcw_switch.sv]
// Time slot switch driven by per-channel connection words.
module tcw_switch (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BIT_CLK,
  input wire logic FRAME_N,
  input wire logic [7:0] RX,
  output logic [7:0] TX,
  output logic [7:0] TX_OE,
  output logic CONTROL_CHANNEL_OUT,
  input wire logic CM_WE,
  input wire logic [7:0] CM_ADDR,
  input wire logic [15:0] CM_WDATA,
  output logic [15:0] CM_RDATA
);

  // Reset release through two flops
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Pin synchronisers; edge detect looks only at second and third stage
  logic bclk_s1_r, bclk_s2_r, bclk_s3_r;
  logic fp_s1_r, fp_s2_r, fp_s3_r;
  logic [7:0] rx_s1_r, rx_s2_r;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      // Idle level of the bit clock, so release shows no false edge
      bclk_s1_r <= 1'b1;
      bclk_s2_r <= 1'b1;
      bclk_s3_r <= 1'b1;
      fp_s1_r <= 1'b1;
      fp_s2_r <= 1'b1;
      fp_s3_r <= 1'b1;
      rx_s1_r <= 8'h00;
      rx_s2_r <= 8'h00;
    end else begin
      bclk_s1_r <= BIT_CLK;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
      fp_s1_r <= FRAME_N;
      fp_s2_r <= fp_s1_r;
      fp_s3_r <= fp_s2_r;
      rx_s1_r <= RX;
      rx_s2_r <= rx_s1_r;
    end
  end

  logic fall, rise, fp_edge;
  assign fall = bclk_s3_r & ~bclk_s2_r;
  assign rise = ~bclk_s3_r & bclk_s2_r;
  assign fp_edge = fp_s3_r & ~fp_s2_r;

  // Memories: connection words, newest bytes, and two frame banks
  tcw_pkg::tcw_cword_t cm_mem [tcw_pkg::NUM_WORDS];
  logic [7:0] dm_live [tcw_pkg::NUM_WORDS];
  logic [7:0] dm_bank [2][tcw_pkg::NUM_WORDS];

  function automatic logic [7:0] slot_addr(input logic [2:0] s,
                                           input logic [4:0] c);
    tcw_pkg::tcw_slot_t a;
    a.stream = s;
    a.chan = c;
    return a;
  endfunction : slot_addr

  // Slot timing state
  tcw_pkg::tcw_state_t state_r, state_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [4:0] ch_r, ch_nxt;
  logic bank_r, bank_nxt;
  logic fp_seen_r, fp_seen_nxt;
  logic [7:0] tx_sh_r [tcw_pkg::NUM_STREAMS];
  logic [7:0] tx_sh_nxt [tcw_pkg::NUM_STREAMS];
  logic [7:0] rx_sh_r [tcw_pkg::NUM_STREAMS];
  logic [7:0] rx_sh_nxt [tcw_pkg::NUM_STREAMS];
  logic [7:0] oe_r, oe_nxt;
  logic [7:0] lp_r, lp_nxt;
  logic ctl_r, ctl_nxt;
  logic load;
  logic [7:0] dm_we;
  logic [7:0] rx_bit;

  always_comb begin
    tcw_pkg::tcw_cword_t w;
    logic [7:0] src;
    w = '0;
    src = 8'h00;
    state_nxt = state_r;
    bit_nxt = bit_r;
    ch_nxt = ch_r;
    bank_nxt = bank_r;
    fp_seen_nxt = fp_seen_r;
    oe_nxt = oe_r;
    lp_nxt = lp_r;
    ctl_nxt = ctl_r;
    load = 1'b0;
    dm_we = 8'h00;
    rx_bit = 8'h00;
    // A frame pulse that lands on the consuming edge is kept
    if (fall) begin
      fp_seen_nxt = 1'b0;
    end
    if (fp_edge) begin
      fp_seen_nxt = 1'b1;
    end
    if (fall && fp_seen_r) begin
      state_nxt = tcw_pkg::ST_RUN;
      bit_nxt = 3'h0;
      ch_nxt = 5'h00;
      bank_nxt = ~bank_r;
      load = 1'b1;
    end else if (fall && state_r == tcw_pkg::ST_RUN) begin
      bit_nxt = bit_r + 3'h1;
      if (bit_r == tcw_pkg::LAST_BIT) begin
        load = 1'b1;
        // Channel 31 wraps to 0 even without a new frame pulse
        ch_nxt = (ch_r == tcw_pkg::LAST_CHANNEL) ? 5'h00 : ch_r + 5'h01;
      end
    end
    for (int s = 0; s < tcw_pkg::NUM_STREAMS; s++) begin
      tx_sh_nxt[s] = tx_sh_r[s];
      rx_sh_nxt[s] = rx_sh_r[s];
      rx_bit[s] = lp_r[s] ? tx_sh_r[s][7] : rx_s2_r[s];
      if (rise && state_r == tcw_pkg::ST_RUN) begin
        rx_sh_nxt[s] = {rx_sh_r[s][6:0], rx_bit[s]};
        dm_we[s] = (bit_r == tcw_pkg::LAST_BIT);
      end
      if (load) begin
        w = cm_mem[slot_addr(3'(s), ch_nxt)];
        // Variable delay takes the newest byte, constant the last frame's
        if (w.const_delay) begin
          src = dm_bank[~bank_nxt][slot_addr(w.source_stream_sel,
                                             w.source_channel_sel)];
        end else begin
          src = dm_live[slot_addr(w.source_stream_sel,
                                  w.source_channel_sel)];
        end
        tx_sh_nxt[s] = w.processor_channel ? w[7:0] : src;
        oe_nxt[s] = w.output_enable;
        lp_nxt[s] = w.loopback;
      end else if (fall && state_r == tcw_pkg::ST_RUN) begin
        tx_sh_nxt[s] = {tx_sh_r[s][6:0], 1'b0};
      end
    end
    // Bit position in the slot doubles as the stream number, stream 0 first
    if (fall && state_nxt == tcw_pkg::ST_RUN) begin
      ctl_nxt = cm_mem[slot_addr(bit_nxt, ch_nxt + 5'h01)]
                .control_channel_out;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= tcw_pkg::ST_HUNT;
      bit_r <= 3'h0;
      ch_r <= 5'h00;
      bank_r <= 1'b0;
      fp_seen_r <= 1'b0;
      oe_r <= 8'h00;
      lp_r <= 8'h00;
      ctl_r <= 1'b0;
      for (int s = 0; s < tcw_pkg::NUM_STREAMS; s++) begin
        tx_sh_r[s] <= 8'h00;
        rx_sh_r[s] <= 8'h00;
      end
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      ch_r <= ch_nxt;
      bank_r <= bank_nxt;
      fp_seen_r <= fp_seen_nxt;
      oe_r <= oe_nxt;
      lp_r <= lp_nxt;
      ctl_r <= ctl_nxt;
      for (int s = 0; s < tcw_pkg::NUM_STREAMS; s++) begin
        tx_sh_r[s] <= tx_sh_nxt[s];
        rx_sh_r[s] <= rx_sh_nxt[s];
      end
    end
  end

  // Data memory is cleared so the first frame never sends unknown bits
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tcw_pkg::NUM_WORDS; i++) begin
        dm_live[i] <= 8'h00;
        dm_bank[0][i] <= 8'h00;
        dm_bank[1][i] <= 8'h00;
      end
    end else begin
      for (int s = 0; s < tcw_pkg::NUM_STREAMS; s++) begin
        if (dm_we[s]) begin
          dm_live[slot_addr(3'(s), ch_r)] <= rx_sh_nxt[s];
          dm_bank[bank_r][slot_addr(3'(s), ch_r)] <= rx_sh_nxt[s];
        end
      end
    end
  end

  // Host port; bits 10, 6 and 5 are stored as written
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < tcw_pkg::NUM_WORDS; i++) begin
        cm_mem[i] <= tcw_pkg::CWORD_RESET;
      end
      CM_RDATA <= 16'h0000;
    end else begin
      if (CM_WE) begin
        cm_mem[CM_ADDR] <= CM_WDATA;
      end
      CM_RDATA <= cm_mem[CM_ADDR];
    end
  end

  // TX outputs float and CONTROL_CHANNEL_OUT stays low until the first frame pulse has aligned the slots
  always_comb begin
    for (int s = 0; s < tcw_pkg::NUM_STREAMS; s++) begin
      TX[s] = tx_sh_r[s][7];
    end
    TX_OE = (state_r == tcw_pkg::ST_RUN) ? oe_r : 8'h00;
    CONTROL_CHANNEL_OUT = ctl_r;
  end

endmodule : tcw_switch

// [pkg/tcw_pkg.sv]
// Constants and types of the connection word decoder.
package tcw_pkg;

  localparam int NUM_STREAMS = 8;
  localparam int NUM_CHANNELS = 32;
  localparam int NUM_WORDS = NUM_STREAMS * NUM_CHANNELS;
  localparam logic [2:0] LAST_STREAM = 3'h7;
  localparam logic [4:0] LAST_CHANNEL = 5'h1F;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [15:0] CWORD_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b01,
    ST_RUN = 2'b10
  } tcw_state_t;

  // Connection word layout, bit 15 first
  typedef struct packed {
    logic loopback;
    logic const_delay;
    logic processor_channel;
    logic control_channel_out;
    logic output_enable;
    logic unused10;
    logic [2:0] source_stream_sel;
    logic [1:0] unused65;
    logic [4:0] source_channel_sel;
  } tcw_cword_t;

  // Memory address of one stream and channel
  typedef struct packed {
    logic [2:0] stream;
    logic [4:0] chan;
  } tcw_slot_t;

endpackage : tcw_pkg

// [verification/tcw_stream_model.sv]
// Serial stream partner: bit clock, frame pulse and receive bits.
module tcw_stream_model (
  input wire logic CLK,
  input wire logic go,
  output logic BIT_CLK,
  output logic FRAME_N,
  output logic [7:0] RX,
  output logic [4:0] ch,
  output logic [2:0] bt,
  output int fr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    logic [7:0] b;
    BIT_CLK = 1'b1;
    FRAME_N = 1'b1;
    RX = 8'h00;
    fr = 0;
    wait (go);
    forever begin
      @(negedge CLK) FRAME_N = 1'b0;
      fr++;
      for (int i = 0; i < 256; i++) begin
        repeat (6) @(negedge CLK);
        {BIT_CLK, FRAME_N, ch, bt} = {2'b01, i[7:0]};
        for (int s = 0; s < 8; s++) begin
          // Byte moves with the frame count so the two delay modes differ
          b = {s[2:0], ch} ^ 8'h5A ^ fr[7:0];
          RX[s] = b[3'h7 - bt];
        end
        repeat (7) @(negedge CLK);
        BIT_CLK = 1'b1;
      end
    end
  end
endmodule : tcw_stream_model

// [verification/tcw_switch_monitor.sv]
// Port assertions for the connection word switch.
module tcw_switch_monitor (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BIT_CLK,
  input wire logic FRAME_N,
  input wire logic CONTROL_CHANNEL_OUT,
  input wire logic CM_WE,
  input wire logic [7:0] TX,
  input wire logic [7:0] TX_OE,
  input wire logic [7:0] CM_ADDR,
  input wire logic [15:0] CM_WDATA,
  input wire logic [15:0] CM_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem_r [256];
  logic [15:0] rd_r;
  logic [3:0] sf_r;
  logic bc_r, fp_r;
  // Cycles since the bit clock pin fell; outputs may only move soon after
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < 256; i++) mem_r[i] <= 16'h0000;
      rd_r <= 16'h0000;
      sf_r <= 4'hF;
      bc_r <= 1'b1;
      fp_r <= 1'b0;
    end else begin
      if (CM_WE) mem_r[CM_ADDR] <= CM_WDATA;
      rd_r <= mem_r[CM_ADDR];
      sf_r <= (bc_r && !BIT_CLK) ? 4'h0 : sf_r + 4'(sf_r != 4'hF);
      bc_r <= BIT_CLK;
      fp_r <= fp_r || !FRAME_N;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_rd; CM_RDATA == rd_r; endproperty
  property p_idle;
    !fp_r |-> TX == 8'h00 && TX_OE == 8'h00 && !CONTROL_CHANNEL_OUT;
  endproperty
  property p_tx_fall; $changed(TX) |-> sf_r inside {[1:5]}; endproperty
  property p_oe_fall; $changed(TX_OE) |-> sf_r inside {[1:5]}; endproperty
  property p_ctl_fall;
    $changed(CONTROL_CHANNEL_OUT) |-> sf_r inside {[1:5]};
  endproperty
  property p_tx_hold; $changed(TX) |=> $stable(TX) [*6]; endproperty
  property p_oe_hold; $changed(TX_OE) |=> $stable(TX_OE) [*6]; endproperty
  property p_ctl_hold;
    $changed(CONTROL_CHANNEL_OUT) |=> $stable(CONTROL_CHANNEL_OUT) [*6];
  endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  a_idle: assert property (p_idle) else $error("early out");
  a_tx_fall: assert property (p_tx_fall) else $error("tx edge");
  a_oe_fall: assert property (p_oe_fall) else $error("oe edge");
  a_ctl_fall: assert property (p_ctl_fall) else $error("ctl edge");
  a_tx_hold: assert property (p_tx_hold) else $error("tx hold");
  a_oe_hold: assert property (p_oe_hold) else $error("oe hold");
  a_ctl_hold: assert property (p_ctl_hold) else $error("ctl hold");
  cover property (CM_WE);
  cover property ($rose(TX_OE[0]));
  cover property ($changed(CONTROL_CHANNEL_OUT));
endmodule : tcw_switch_monitor
bind tcw_switch tcw_switch_monitor mon_u (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .BIT_CLK(BIT_CLK),
  .FRAME_N(FRAME_N),
  .CONTROL_CHANNEL_OUT(CONTROL_CHANNEL_OUT),
  .CM_WE(CM_WE),
  .TX(TX),
  .TX_OE(TX_OE),
  .CM_ADDR(CM_ADDR),
  .CM_WDATA(CM_WDATA),
  .CM_RDATA(CM_RDATA)
);

// [verification/tcw_switch_test.sv]
// Self-checking bench for the connection word switch.
module tcw_switch_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RESET_N, CM_WE, go, BIT_CLK, FRAME_N, CONTROL_CHANNEL_OUT;
  logic [7:0] RX, TX, TX_OE, CM_ADDR, sh [8];
  logic [15:0] CM_WDATA, CM_RDATA, r, cw [256];
  logic [4:0] ch;
  logic [2:0] bt;
  int fr, err_count, comparisons, cyc;
  tcw_switch dut_u (.CLK(CLK), .RESET_N(RESET_N), .BIT_CLK(BIT_CLK),
    .FRAME_N(FRAME_N), .RX(RX), .TX(TX), .TX_OE(TX_OE),
    .CONTROL_CHANNEL_OUT(CONTROL_CHANNEL_OUT),
    .CM_WE(CM_WE), .CM_ADDR(CM_ADDR), .CM_WDATA(CM_WDATA),
    .CM_RDATA(CM_RDATA));
  tcw_stream_model part_u (.CLK(CLK), .go(go), .BIT_CLK(BIT_CLK),
    .FRAME_N(FRAME_N), .RX(RX), .ch(ch), .bt(bt), .fr(fr));
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  function automatic logic [7:0] exp_byte(logic [15:0] w);
    logic [7:0] a;
    int f;
    a = {w[9:7], w[4:0]};
    f = fr;
    if (w[13]) return w[7:0];
    // Looped-back sources always carry a fixed byte here
    if (cw[a][15]) return cw[a][7:0];
    // Constant delay, or a source slot not yet received, gives last frame
    if (w[14] || w[4:0] >= ch) f--;
    return a ^ 8'h5A ^ f[7:0];
  endfunction : exp_byte
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  always @(posedge BIT_CLK) begin : mon_b
    logic [15:0] w;
    if (fr >= 2) begin
      check(16'(CONTROL_CHANNEL_OUT),
            16'(cw[{bt, ch + 5'h01}][12]));
      for (int s = 0; s < 8; s++) begin
        w = cw[{s[2:0], ch}];
        check(16'(TX_OE[s]), 16'(w[11]));
        sh[s] = {sh[s][6:0], TX[s]};
        if (bt == 3'h7 && w[11])
          check(16'(sh[s]), 16'(exp_byte(w)));
      end
    end
  end
  initial begin
    RESET_N = 1'b0;
    CM_WE = 1'b0;
    CM_ADDR = 8'h00;
    CM_WDATA = 16'h0000;
    go = 1'b0;
    r = 16'h1B80;
    repeat (20) @(negedge CLK);
    RESET_N = 1'b1;
    repeat (3) @(negedge CLK);
    for (int a = 0; a < 256; a++) begin
      r = lfsr_next(r);
      cw[a] = r & 16'hF99F;
      if (r[15]) cw[a] = cw[a] | 16'h2800;
    end
    cw[8'h21] = 16'hA883;
    cw[8'h42] = 16'h4881;
    cw[8'hFF] = 16'h1B9F;
    // Same earlier source slot read with constant and with variable delay
    cw[8'h40] = 16'h0800;
    cw[8'h43] = 16'h4900;
    cw[8'h44] = 16'h0900;
    for (int a = 0; a < 256; a++) begin
      {CM_WE, CM_ADDR, CM_WDATA} = {1'b1, a[7:0], cw[a]};
      @(negedge CLK);
    end
    CM_WE = 1'b0;
    for (int a = 0; a < 256; a++) begin
      CM_ADDR = a[7:0];
      @(negedge CLK);
      check(CM_RDATA, cw[a]);
    end
    go = 1'b1;
    wait (fr == 4);
    tally_and_finish();
  end
endmodule : tcw_switch_test
